/* File: pkg/ccdrs_regs.svh */
// Constants of the CCD readout sequencer: geometry, timing, register map.
// Assumes a 20 MHz system clock; included by bare name.
`ifndef CCDRS_REGS_SVH
`define CCDRS_REGS_SVH

// Frame geometry in rows
`define CCDRS_DARK_ROWS      10
`define CCDRS_PHOTO_ROWS     2062
`define CCDRS_BUF_ROWS_FIRST 6
`define CCDRS_BUF_ROWS_LAST  8
`define CCDRS_IMAGE_ROWS     2048

// Line geometry in horizontal clock periods
`define CCDRS_EMPTY_PIX        12
`define CCDRS_SHIELD_PIX       28
`define CCDRS_PHOTO_PIX_SINGLE 2056
`define CCDRS_PHOTO_PIX_DUAL   1028
`define CCDRS_BUF_PIX          4
`define CCDRS_IMAGE_COLS       2048
`define CCDRS_LINE_SINGLE      2124
`define CCDRS_LINE_DUAL        1068

// Timing: clock rate, resume delay and vertical pulse width
`define CCDRS_CLK_MHZ          20
`define CCDRS_RESUME_DELAY_NS  1000
`define CCDRS_VPULSE_NS        1000
`define CCDRS_NS_TO_CYC(ns)    ((((ns) * `CCDRS_CLK_MHZ) + 999) / 1000)
`define CCDRS_RESUME_DELAY_CYC `CCDRS_NS_TO_CYC(`CCDRS_RESUME_DELAY_NS)
`define CCDRS_VPULSE_CYC       `CCDRS_NS_TO_CYC(`CCDRS_VPULSE_NS)

// Register byte offsets
`define CCDRS_OFS_CTRL    8'h00
`define CCDRS_OFS_STATUS  8'h04
`define CCDRS_OFS_ROW     8'h08
`define CCDRS_OFS_RESUME  8'h0C
`define CCDRS_OFS_VPULSE  8'h10

// Control fields
`define CCDRS_CTRL_START     0
`define CCDRS_CTRL_DUAL      1
`define CCDRS_CTRL_DUMP_DARK 2
`define CCDRS_CTRL_CONT      3

// Status fields
`define CCDRS_STAT_BUSY      0
`define CCDRS_STAT_DUAL      1
`define CCDRS_STAT_FCNT_LSB  16

`endif

/* File: pkg/ccdrs_pkg.sv */
// Types shared by the CCD readout sequencer modules.
// Assumes the constants header is on the include path.
package ccdrs_pkg;

  typedef logic [11:0] ccdrs_pix_t;
  typedef logic [11:0] ccdrs_row_t;
  typedef logic [10:0] ccdrs_col_t;

  typedef enum logic [1:0] {
    PIX_EMPTY,
    PIX_DARK,
    PIX_BUFFER,
    PIX_IMAGE
  } ccdrs_class_e;

  typedef struct packed {
    ccdrs_class_e cls;
    logic         dark_ref;
    ccdrs_col_t   col;
  } ccdrs_tag_s;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_VFIRST,
    ST_VSECOND,
    ST_RESUME,
    ST_SHIFT
  } ccdrs_state_e;

endpackage

/* File: pkg/ccdrs_cfg_if.sv */
// Configuration and status carrier between the bus slave and the sequencer.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
interface ccdrs_cfg_if;
  logic        start;
  logic        dual;
  logic        dump_dark;
  logic        continuous;
  logic [15:0] resume_cyc;
  logic [15:0] vpulse_cyc;
  logic        busy;
  logic        dual_active;
  logic [11:0] row;
  logic [15:0] frame_count;

  modport regs (
    output start, dual, dump_dark, continuous, resume_cyc, vpulse_cyc,
    input  busy, dual_active, row, frame_count
  );
  modport core (
    input  start, dual, dump_dark, continuous, resume_cyc, vpulse_cyc,
    output busy, dual_active, row, frame_count
  );
endinterface

/* File: hdl/ccdrs_wb_slave.sv */
// Classic Wishbone slave holding the sequencer's control registers.
// Assumes a single-cycle classic master; answers one cycle after request.
`timescale 1ns/1ps
`include "ccdrs_regs.svh"
module ccdrs_wb_slave (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        ce_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [31:0] wb_dat_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic        wb_we_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  ccdrs_cfg_if.regs        cfg
);
  import ccdrs_pkg::*;

  logic        ack_reg;
  logic [31:0] dat_reg;
  logic [3:0]  ctrl_reg;
  logic [15:0] resume_reg;
  logic [15:0] vpulse_reg;
  logic        wr_go;

  // Byte-lane merge for 16-bit fields
  function automatic logic [15:0] merge16(input logic [15:0] old_v,
                                          input logic [15:0] new_v,
                                          input logic [1:0]  sel);
    merge16 = {sel[1] ? new_v[15:8] : old_v[15:8], sel[0] ? new_v[7:0] : old_v[7:0]};
  endfunction

  // Write lands on the edge where the master sees ack
  assign wr_go = wb_cyc_i && wb_stb_i && wb_we_i && ack_reg;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_reg <= 1'b0;
      dat_reg <= 32'h0000_0000;
    end else if (ce_i) begin
      ack_reg <= wb_cyc_i && wb_stb_i && !ack_reg;
      dat_reg <= 32'h0000_0000;
      if (wb_cyc_i && wb_stb_i && !ack_reg && !wb_we_i) begin
        unique case (wb_adr_i)
          `CCDRS_OFS_CTRL:   dat_reg <= {28'h000_0000, ctrl_reg[3:1], 1'b0};
          `CCDRS_OFS_STATUS: dat_reg <= {cfg.frame_count, 14'h0000, cfg.dual_active, cfg.busy};
          `CCDRS_OFS_ROW:    dat_reg <= {20'h0_0000, cfg.row};
          `CCDRS_OFS_RESUME: dat_reg <= {16'h0000, resume_reg};
          `CCDRS_OFS_VPULSE: dat_reg <= {16'h0000, vpulse_reg};
          default:           dat_reg <= 32'h0000_0000;
        endcase
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_reg   <= 4'h0;
      resume_reg <= 16'(`CCDRS_RESUME_DELAY_CYC);
      vpulse_reg <= 16'(`CCDRS_VPULSE_CYC);
    end else if (ce_i) begin
      ctrl_reg[`CCDRS_CTRL_START] <= 1'b0;
      if (wr_go && wb_adr_i == `CCDRS_OFS_CTRL && wb_sel_i[0]) begin
        ctrl_reg <= wb_dat_i[3:0];
      end
      if (wr_go && wb_adr_i == `CCDRS_OFS_RESUME) begin
        resume_reg <= merge16(resume_reg, wb_dat_i[15:0], wb_sel_i[1:0]);
      end
      if (wr_go && wb_adr_i == `CCDRS_OFS_VPULSE) begin
        vpulse_reg <= merge16(vpulse_reg, wb_dat_i[15:0], wb_sel_i[1:0]);
      end
    end
  end

  assign cfg.start      = ctrl_reg[`CCDRS_CTRL_START];
  assign cfg.dual       = ctrl_reg[`CCDRS_CTRL_DUAL];
  assign cfg.dump_dark  = ctrl_reg[`CCDRS_CTRL_DUMP_DARK];
  assign cfg.continuous = ctrl_reg[`CCDRS_CTRL_CONT];
  assign cfg.resume_cyc = resume_reg;
  assign cfg.vpulse_cyc = vpulse_reg;
  assign wb_dat_o       = dat_reg;
  assign wb_ack_o       = ack_reg;
endmodule

/* File: hdl/ccdrs_top.sv */
// Camera timing generator for an interline CCD readout: drives the
// vertical and horizontal phases and the line dump, and tags each pixel.
// Assumes the sensor pins are buffered by external clock drivers and
// that the right-half horizontal drivers are wired for the chosen mode.
//
// Behaviour
// RL1 - Dark rows read first, then photoactive rows
// RL2 - Photoactive rows: buffer, image, buffer rows
// RL3 - Single mode: left output, empty pixels first
// RL4 - Empty, shielded, photosensitive, shielded pixel order
// RL5 - Edge photosensitive pixels are buffer pixels
// RL6 - Dual mode: right half shifts reversed
// RL7 - Dual halves: empty, shielded, half photosensitive
// RL8 - Right half stored reversed after left
// RL9 - Dark rows never used as reference
// RL10 - Dark reference: central shielded columns only
// RL11 - Vertical pulse moves one row into register
// RL12 - During vertical shift: phase a high, b low
// RL13 - Resume horizontal only after hold-off delay
// RL14 - Row lands in storage phase of a
// RL15 - Dump held high across transfer discards line
// RL16 - No vertical or dump pulses while shifting
// RL17 - Single mode: fixed periods per line
// RL18 - Dual mode: fixed periods per half
// RL19 - Counters follow selected output mode
// RL20 - Every pixel period tagged by class
`timescale 1ns/1ps
`include "ccdrs_regs.svh"
module ccdrs_top #(
  parameter int N_DARK_ROWS  = `CCDRS_DARK_ROWS,
  parameter int N_PHOTO_ROWS = `CCDRS_PHOTO_ROWS,
  parameter int TIMER_W      = 16
) (
  input  wire logic                clk_i,
  input  wire logic                rst_i,
  input  wire logic                ce_i,
  input  wire logic [7:0]          wb_adr_i,
  input  wire logic [31:0]         wb_dat_i,
  input  wire logic [3:0]          wb_sel_i,
  input  wire logic                wb_we_i,
  input  wire logic                wb_cyc_i,
  input  wire logic                wb_stb_i,
  output logic      [31:0]         wb_dat_o,
  output logic                     wb_ack_o,
  output logic                     vertical_phase_first_o,
  output logic                     vertical_phase_second_o,
  output logic                     horizontal_phase_a_o,
  output logic                     horizontal_phase_b_o,
  output logic                     fast_line_dump_o,
  output logic                     dual_mode_o,
  output logic                     pix_strobe_o,
  output ccdrs_pkg::ccdrs_row_t    pix_row_o,
  output ccdrs_pkg::ccdrs_class_e  left_class_o,
  output logic                     left_dark_ref_o,
  output ccdrs_pkg::ccdrs_col_t    left_col_o,
  output ccdrs_pkg::ccdrs_class_e  right_class_o,
  output logic                     right_dark_ref_o,
  output ccdrs_pkg::ccdrs_col_t    right_col_o,
  output logic                     frame_done_o
);
  import ccdrs_pkg::*;

  localparam int ROWS_TOTAL = N_DARK_ROWS + N_PHOTO_ROWS;

  // Elaboration-time refusal of row counts and timer widths outside the supported range
  if (ROWS_TOTAL > 4095 || N_PHOTO_ROWS <= `CCDRS_BUF_ROWS_FIRST + `CCDRS_BUF_ROWS_LAST) begin
    $error("ccdrs_top: row counts out of range");
  end
  if (TIMER_W < 16 || TIMER_W > 31) begin
    $error("ccdrs_top: TIMER_W must be 16..31");
  end

  localparam ccdrs_row_t LAST_ROW     = ccdrs_row_t'(ROWS_TOTAL - 1);
  localparam ccdrs_row_t DARK_ROWS    = ccdrs_row_t'(N_DARK_ROWS);
  localparam ccdrs_row_t IMG_ROW_LO   = ccdrs_row_t'(N_DARK_ROWS + `CCDRS_BUF_ROWS_FIRST);
  localparam ccdrs_row_t IMG_ROW_HI   = ccdrs_row_t'(ROWS_TOTAL - `CCDRS_BUF_ROWS_LAST);
  localparam ccdrs_pix_t EMPTY_END    = ccdrs_pix_t'(`CCDRS_EMPTY_PIX);
  localparam ccdrs_pix_t SHIELD_END   = ccdrs_pix_t'(`CCDRS_EMPTY_PIX + `CCDRS_SHIELD_PIX);
  localparam ccdrs_pix_t PHOTO_SINGLE = ccdrs_pix_t'(`CCDRS_PHOTO_PIX_SINGLE);
  localparam ccdrs_pix_t PHOTO_DUAL   = ccdrs_pix_t'(`CCDRS_PHOTO_PIX_DUAL);
  localparam ccdrs_pix_t BUF_PIX      = ccdrs_pix_t'(`CCDRS_BUF_PIX);
  localparam ccdrs_pix_t LAST_SINGLE  = ccdrs_pix_t'(`CCDRS_LINE_SINGLE - 1);
  localparam ccdrs_pix_t LAST_DUAL    = ccdrs_pix_t'(`CCDRS_LINE_DUAL - 1);
  localparam ccdrs_col_t LAST_COL     = ccdrs_col_t'(`CCDRS_IMAGE_COLS - 1);

  ccdrs_cfg_if cfg ();

  ccdrs_wb_slave u_wb_slave (
    .clk_i    (clk_i),
    .rst_i    (rst_i),
    .ce_i     (ce_i),
    .wb_adr_i (wb_adr_i),
    .wb_dat_i (wb_dat_i),
    .wb_sel_i (wb_sel_i),
    .wb_we_i  (wb_we_i),
    .wb_cyc_i (wb_cyc_i),
    .wb_stb_i (wb_stb_i),
    .wb_dat_o (wb_dat_o),
    .wb_ack_o (wb_ack_o),
    .cfg      (cfg)
  );

  ccdrs_state_e       state_reg;
  logic [TIMER_W-1:0] timer_reg;
  ccdrs_row_t         row_reg;
  ccdrs_pix_t         pix_reg;
  logic               half_reg;
  logic               dual_reg;
  logic               dump_reg;
  logic               cont_reg;
  logic [15:0]        fcount_reg;
  logic               v1_reg;
  logic               v2_reg;
  logic               ha_reg;
  logic               hb_reg;
  logic               row_end;
  logic               tag_go;
  ccdrs_pix_t         last_pix;
  logic               photo_row;
  logic               image_row;
  ccdrs_tag_s         tag_l;
  ccdrs_tag_s         tag_r;

  // Dark-row dump only applies to the shielded rows read first
  function automatic logic dump_row(input ccdrs_row_t r, input logic enable);
    dump_row = enable && (r < DARK_ROWS);
  endfunction

  // Classify one output's pixel period in line order
  function automatic ccdrs_tag_s classify(input ccdrs_pix_t p,
                                          input logic       dual,
                                          input logic       photo,
                                          input logic       image);
    ccdrs_tag_s r;
    ccdrs_pix_t nphoto;
    ccdrs_pix_t hi;
    ccdrs_pix_t q;
    r      = '0;
    nphoto = dual ? PHOTO_DUAL : PHOTO_SINGLE;
    // Dual halves carry buffer pixels only at the outer edge
    hi     = dual ? nphoto : nphoto - BUF_PIX;
    q      = p - SHIELD_END;
    if (p < EMPTY_END) begin
      r.cls = PIX_EMPTY;                                          // see RL3
    end else if (p < SHIELD_END) begin
      r.cls      = PIX_DARK;                                      // see RL4
      r.dark_ref = photo && p != EMPTY_END && p != SHIELD_END - 12'h001; // see RL10
    end else if (q < nphoto) begin
      r.cls = (image && q >= BUF_PIX && q < hi) ? PIX_IMAGE : PIX_BUFFER; // see RL5
      r.col = ccdrs_col_t'(q - BUF_PIX);
    end else begin
      r.cls      = PIX_DARK;                                      // see RL4
      r.dark_ref = photo && q != nphoto && p != LAST_SINGLE;      // see RL10
    end
    return r;
  endfunction

  // Line length follows the latched mode
  assign last_pix  = dual_reg ? LAST_DUAL : LAST_SINGLE;         // see RL17, RL18, RL19
  // Rows nearest the register come out first
  assign photo_row = row_reg >= DARK_ROWS;                        // see RL1, RL9
  assign image_row = row_reg >= IMG_ROW_LO && row_reg < IMG_ROW_HI; // see RL2
  assign row_end   = (state_reg == ST_RESUME && timer_reg == '0 && dump_reg) ||
                     (state_reg == ST_SHIFT && half_reg && pix_reg == last_pix);
  assign tag_go    = state_reg == ST_SHIFT && half_reg;

  always_comb begin
    tag_l = classify(pix_reg, dual_reg, photo_row, image_row);
    tag_r = tag_l;
  end

  // Sequencer state, counters and sensor pins
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_reg  <= ST_IDLE;
      timer_reg  <= '0;
      row_reg    <= '0;
      pix_reg    <= '0;
      half_reg   <= 1'b0;
      dual_reg   <= 1'b0;
      dump_reg   <= 1'b0;
      cont_reg   <= 1'b0;
      v1_reg     <= 1'b0;
      v2_reg     <= 1'b0;
      ha_reg     <= 1'b1;
      hb_reg     <= 1'b0;
    end else if (ce_i) begin
      unique case (state_reg)
        ST_IDLE: begin
          ha_reg <= 1'b1;
          hb_reg <= 1'b0;
          if (cfg.start) begin
            dual_reg  <= cfg.dual;                                // see RL19
            cont_reg  <= cfg.continuous;
            row_reg   <= '0;
            dump_reg  <= dump_row('0, cfg.dump_dark);             // see RL15
            v1_reg    <= 1'b1;                                    // see RL11
            timer_reg <= TIMER_W'(cfg.vpulse_cyc);
            state_reg <= ST_VFIRST;
          end
        end
        ST_VFIRST: begin
          timer_reg <= timer_reg - 1'b1;
          if (timer_reg <= 1) begin
            v1_reg    <= 1'b0;
            v2_reg    <= 1'b1;                                    // see RL11, RL14
            timer_reg <= TIMER_W'(cfg.vpulse_cyc);
            state_reg <= ST_VSECOND;
          end
        end
        ST_VSECOND: begin
          timer_reg <= timer_reg - 1'b1;
          if (timer_reg <= 1) begin
            v2_reg    <= 1'b0;
            // Count starts at the falling edge just made
            timer_reg <= (cfg.resume_cyc == 16'h0000) ? '0 :
                         TIMER_W'(cfg.resume_cyc - 16'h0001);     // see RL13
            state_reg <= ST_RESUME;
          end
        end
        ST_RESUME: begin
          timer_reg <= timer_reg - 1'b1;
          if (timer_reg == '0) begin
            // Dump released before any horizontal clocking
            dump_reg  <= 1'b0;                                    // see RL16
            pix_reg   <= '0;
            half_reg  <= 1'b0;
            // Phase a drops here so each strobe meets its rising edge
            ha_reg    <= 1'b0;                                    // see RL13
            hb_reg    <= 1'b1;
            state_reg <= ST_SHIFT;
          end
        end
        ST_SHIFT: begin
          half_reg <= !half_reg;
          ha_reg   <= !half_reg;
          hb_reg   <= half_reg;
          if (half_reg) begin
            pix_reg <= pix_reg + 12'h001;                         // see RL17, RL18
          end
        end
        default: state_reg <= ST_IDLE;
      endcase
      // Row finished: next transfer, frame wrap or stop
      if (row_end) begin
        ha_reg <= 1'b1;                                           // see RL12
        hb_reg <= 1'b0;
        if (row_reg == LAST_ROW && !cont_reg) begin
          state_reg <= ST_IDLE;
        end else begin
          row_reg   <= (row_reg == LAST_ROW) ? '0 : row_reg + 12'h001;
          dump_reg  <= dump_row((row_reg == LAST_ROW) ? '0 : row_reg + 12'h001,
                                cfg.dump_dark);                   // see RL15
          v1_reg    <= 1'b1;
          timer_reg <= TIMER_W'(cfg.vpulse_cyc);
          state_reg <= ST_VFIRST;
        end
      end
    end
  end

  // Frame counter and frame-done pulse
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fcount_reg   <= 16'h0000;
      frame_done_o <= 1'b0;
    end else if (ce_i) begin
      frame_done_o <= row_end && row_reg == LAST_ROW;
      if (row_end && row_reg == LAST_ROW) begin
        fcount_reg <= fcount_reg + 16'h0001;
      end
    end
  end

  // Pixel tags, issued with the rising half of phase a
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pix_strobe_o     <= 1'b0;
      pix_row_o        <= '0;
      left_class_o     <= PIX_EMPTY;
      left_dark_ref_o  <= 1'b0;
      left_col_o       <= '0;
      right_class_o    <= PIX_EMPTY;
      right_dark_ref_o <= 1'b0;
      right_col_o      <= '0;
    end else if (ce_i) begin
      pix_strobe_o <= tag_go;                                     // see RL20
      if (tag_go) begin
        pix_row_o       <= row_reg;
        left_class_o    <= tag_l.cls;
        left_dark_ref_o <= tag_l.dark_ref;
        left_col_o      <= tag_l.col;
        // Right class and reference mirror the left in dual mode only; the right column is reversed in both modes
        right_class_o    <= dual_reg ? tag_r.cls : PIX_EMPTY;     // see RL6, RL7
        right_dark_ref_o <= dual_reg && tag_r.dark_ref;
        // Reversed placement appended after the left half
        right_col_o      <= LAST_COL - tag_r.col;                 // see RL8
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      vertical_phase_first_o  <= 1'b0;
      vertical_phase_second_o <= 1'b0;
      horizontal_phase_a_o    <= 1'b1;
      horizontal_phase_b_o    <= 1'b0;
      fast_line_dump_o        <= 1'b0;
      dual_mode_o             <= 1'b0;
    end else if (ce_i) begin
      vertical_phase_first_o  <= v1_reg;
      vertical_phase_second_o <= v2_reg;
      horizontal_phase_a_o    <= ha_reg;
      horizontal_phase_b_o    <= hb_reg;
      fast_line_dump_o        <= dump_reg;
      dual_mode_o             <= dual_reg;                        // see RL6
    end
  end

  assign cfg.busy        = state_reg != ST_IDLE;
  assign cfg.dual_active = dual_reg;
  assign cfg.row         = row_reg;
  assign cfg.frame_count = fcount_reg;
endmodule

/* File: tb/ccdrs_top_properties.sv */
// Checker for the readout sequencer top: phase timing, tags, bus answer.
// Sees top ports only; assumes register defaults of 20 cycles stay set.
`timescale 1ns/1ps
module ccdrs_top_chk #(
  parameter int N_DARK_ROWS = 10
) (
  input wire logic                   clk_i,
  input wire logic                   rst_i,
  input wire logic                   wb_stb_i,
  input wire logic                   wb_ack_o,
  input wire logic                   vertical_phase_first_o,
  input wire logic                   vertical_phase_second_o,
  input wire logic                   horizontal_phase_a_o,
  input wire logic                   horizontal_phase_b_o,
  input wire logic                   fast_line_dump_o,
  input wire logic                   pix_strobe_o,
  input wire ccdrs_pkg::ccdrs_row_t  pix_row_o,
  input wire ccdrs_pkg::ccdrs_class_e left_class_o,
  input wire logic                   left_dark_ref_o,
  input wire logic                   right_dark_ref_o
);
  import ccdrs_pkg::*;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  wire        va  = vertical_phase_first_o;
  wire        vb  = vertical_phase_second_o;
  wire        ha  = horizontal_phase_a_o;
  wire        hb  = horizontal_phase_b_o;
  wire        dmp = fast_line_dump_o;
  logic [7:0] since_v_reg;
  // Cycles since the last vertical pulse, saturating
  always_ff @(posedge clk_i) begin
    if (rst_i || va || vb) since_v_reg <= 8'h00;
    else if (since_v_reg != 8'hff) since_v_reg <= since_v_reg + 8'h01;
  end
  property p_hold_h; (va || vb) |-> ha && !hb; endproperty
  a_hold_h: assert property (p_hold_h) else $error("h clock not parked");
  property p_v_seq; $rose(va) |-> ##19 va ##1 (!va && vb); endproperty
  a_v_seq: assert property (p_v_seq) else $error("vertical pulse wrong");
  property p_resume; $fell(ha) |-> since_v_reg >= 8'h14; endproperty
  a_resume: assert property (p_resume) else $error("h clock too early");
  property p_quiet; !ha |-> !va && !vb && !dmp; endproperty
  a_quiet: assert property (p_quiet) else $error("pulse during shift");
  property p_dump_h; dmp |-> ha && !hb && !pix_strobe_o; endproperty
  a_dump_h: assert property (p_dump_h) else $error("h clock in dump");
  property p_pix; !ha |=> ha && pix_strobe_o; endproperty
  a_pix: assert property (p_pix) else $error("pixel period wrong");
  property p_strobe; pix_strobe_o |-> $rose(ha); endproperty
  a_strobe: assert property (p_strobe) else $error("stray strobe");
  property p_ref_cls; left_dark_ref_o |-> left_class_o == PIX_DARK; endproperty
  a_ref_cls: assert property (p_ref_cls) else $error("ref not dark");
  property p_dark_rows;
    pix_strobe_o && pix_row_o < N_DARK_ROWS |-> !left_dark_ref_o && !right_dark_ref_o;
  endproperty
  a_dark_rows: assert property (p_dark_rows) else $error("dark row as ref");
  property p_ack; $rose(wb_stb_i) |=> wb_ack_o ##1 !wb_ack_o; endproperty
  a_ack: assert property (p_ack) else $error("bus answer wrong");
endmodule
bind ccdrs_top ccdrs_top_chk #(.N_DARK_ROWS(N_DARK_ROWS)) u_chk (.*);

/* File: tb/ccdrs_sensor_model.sv */
// Behavioural sensor: counts rows moved, rows dumped and line lengths.
// Sampled on the system clock, since the pins are registered there.
`timescale 1ns/1ps
module ccdrs_sensor_model (
  input  wire logic clk_i,
  input  wire logic va_i,
  input  wire logic vb_i,
  input  wire logic ha_i,
  input  wire logic dump_i,
  output int        rows_o,
  output int        dumped_o,
  output int        len_o
);
  logic vb_q  = 1'b0;
  logic ha_q  = 1'b1;
  logic dmp_q = 1'b0;
  int   cnt   = 0;
  initial {rows_o, dumped_o, len_o} = 0;
  always @(posedge clk_i) begin
    vb_q <= vb_i;
    ha_q <= ha_i;
    if (va_i) dmp_q <= dump_i;
    if (ha_i && !ha_q) cnt <= cnt + 1;
    if (vb_q && !vb_i) begin
      if (dmp_q && dump_i) dumped_o <= dumped_o + 1;
      else begin
        rows_o <= rows_o + 1;
        len_o <= cnt;
        cnt <= 0;
      end
    end
  end
endmodule

/* File: tb/ccdrs_top_bench.sv */
// Bench for the readout sequencer: bus, single and dual line tagging.
// Assumes design, checker and sensor model are compiled before it.
`timescale 1ns/1ps
module ccdrs_top_bench;
  import ccdrs_pkg::*;
  localparam int ND = 2;
  localparam int NP = 15;
  logic         clk_i, rst_i, ce_i, wb_we_i, wb_cyc_i, wb_stb_i, wb_ack_o;
  logic [7:0]   wb_adr_i, a;
  logic [31:0]  wb_dat_i, wb_dat_o, q;
  logic [3:0]   wb_sel_i;
  logic         vertical_phase_first_o, vertical_phase_second_o, fast_line_dump_o;
  logic         horizontal_phase_a_o, horizontal_phase_b_o, dual_mode_o;
  logic         pix_strobe_o, left_dark_ref_o, right_dark_ref_o, frame_done_o;
  ccdrs_row_t   pix_row_o, lrow;
  ccdrs_class_e left_class_o, right_class_o, ec;
  ccdrs_col_t   left_col_o, right_col_o;
  int           n_mismatch, n_checks, n_cyc, pidx, m_rows, m_dump, m_len, r0, d0, k;
  bit           dual_m;

  ccdrs_top #(.N_DARK_ROWS(ND), .N_PHOTO_ROWS(NP)) uut (.*);
  ccdrs_sensor_model sm (.clk_i(clk_i), .va_i(vertical_phase_first_o),
    .vb_i(vertical_phase_second_o), .ha_i(horizontal_phase_a_o),
    .dump_i(fast_line_dump_o), .rows_o(m_rows), .dumped_o(m_dump), .len_o(m_len));

  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end

  task automatic finish_test;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    n_checks++;
    if (s !== e) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", nm, e, s);
    end
  endtask

  // Holds the request until ack is sampled high, then idles one cycle
  task automatic bus(input logic [7:0] ad, input logic [31:0] d, input logic w,
                     output logic [31:0] rd);
    wb_adr_i <= ad;
    wb_dat_i <= d;
    wb_we_i  <= w;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    do @(posedge clk_i); while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clk_i);
  endtask

  function automatic ccdrs_class_e ecls(int i, int r, bit d);
    int p;
    p = i - 40;
    if (i < 12) return PIX_EMPTY;
    if (p < 0 || p >= (d ? 1028 : 2056)) return PIX_DARK;
    if (r < ND + 6 || r >= ND + NP - 8 || p < 4 || (!d && p >= 2052)) return PIX_BUFFER;
    return PIX_IMAGE;
  endfunction

  function automatic logic eref(int i, int r, bit d);
    return r >= ND && ((i >= 13 && i <= 38) || (!d && i >= 2097 && i <= 2122));
  endfunction

  always @(posedge clk_i) begin
    n_cyc++;
    if (n_cyc == 95000) begin
      n_mismatch++;
      finish_test;
    end
  end

  // Pixel tags checked at mid-cycle, where registered outputs are settled
  always @(negedge clk_i) begin
    if (pix_strobe_o === 1'b1 && rst_i === 1'b0) begin
      if (pix_row_o !== lrow) begin
        if (pidx > 0) chk("line length", pidx, dual_m ? 1068 : 2124);
        pidx = 0;
        lrow = pix_row_o;
      end
      ec = ecls(pidx, pix_row_o, dual_m);
      chk("mode pin", dual_mode_o, dual_m);
      chk("left class", left_class_o, ec);
      chk("left ref", left_dark_ref_o, eref(pidx, pix_row_o, dual_m));
      chk("right ref", right_dark_ref_o, dual_m && eref(pidx, pix_row_o, dual_m));
      chk("right class", right_class_o, dual_m ? ec : PIX_EMPTY);
      if (ec == PIX_IMAGE) chk("left col", left_col_o, pidx - 44);
      if (ec == PIX_IMAGE && dual_m) chk("right col", right_col_o, 2091 - pidx);
      pidx++;
    end
  end

  initial begin
    void'($urandom(32'h16c3_dfef));
    {ce_i, wb_cyc_i, wb_stb_i, wb_we_i} = 4'h8;
    wb_adr_i = 8'h00;
    wb_dat_i = 32'h0000_0000;
    wb_sel_i = 4'hf;
    rst_i = 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    bus(8'h0c, 32'h0000_0000, 1'b0, q);
    chk("resume reset", q, 32'h0000_0014);
    bus(8'h10, 32'h0000_0000, 1'b0, q);
    chk("vpulse reset", q, 32'h0000_0014);
    for (k = 0; k < 4; k++) begin
      a = 8'h14 + 8'(4 * ($urandom % 50));
      bus(a, $urandom, 1'b1, q);
      bus(a, 32'h0000_0000, 1'b0, q);
      chk("unmapped", q, 32'h0000_0000);
    end
    // Upper byte lane only, then restore the default hold-off
    wb_sel_i <= 4'h2;
    bus(8'h0c, 32'h0000_ab77, 1'b1, q);
    wb_sel_i <= 4'hf;
    bus(8'h0c, 32'h0000_0000, 1'b0, q);
    chk("byte lane", q, 32'h0000_ab14);
    bus(8'h0c, 32'h0000_0014, 1'b1, q);
    // Single mode, dark rows dumped; cut by a reset after the image row
    dual_m = 1'b0;
    r0 = m_rows;
    d0 = m_dump;
    bus(8'h00, 32'h0000_0005, 1'b1, q);
    bus(8'h04, 32'h0000_0000, 1'b0, q);
    chk("busy", q[0], 1'b1);
    bus(8'h00, 32'h0000_0000, 1'b0, q);
    chk("ctrl readback", q, 32'h0000_0004);
    wait (m_rows == r0 + 8);
    repeat (100) @(posedge clk_i);
    chk("dumped rows", m_dump - d0, ND);
    chk("model line", m_len, 2124);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    pidx = 0;
    // Dual mode, full frame, dark rows clocked out
    dual_m = 1'b1;
    r0 = m_rows;
    bus(8'h00, 32'h0000_0003, 1'b1, q);
    @(posedge clk_i iff frame_done_o === 1'b1);
    chk("rows moved", m_rows - r0, ND + NP);
    chk("model half line", m_len, 1068);
    repeat (2) @(posedge clk_i);
    bus(8'h04, 32'h0000_0000, 1'b0, q);
    chk("frame count", q[31:16], 1);
    chk("idle", q[0], 1'b0);
    finish_test;
  end
endmodule
